// file: common/clock_prescaler_wakeup_defines.vh
// constants for the clock prescaler and wake-up wait block
// assumes a 100 MHz reference clock and a 32-bit APB register port
`ifndef CLOCK_PRESCALER_WAKEUP_DEFINES_VH
`define CLOCK_PRESCALER_WAKEUP_DEFINES_VH

// ============================================================
// register byte offsets
`define OFS_PORT_MODE_REG_TWO 12'h000
`define OFS_SYSTEM_CONTROL_REG_ONE 12'h004
`define OFS_TIMER_A_MODE_REG 12'h008
`define OFS_STATUS 12'h00c

// ============================================================
// field positions
`define EXT_SUBCLOCK_SELECT_BIT 7
`define STANDBY_WAIT_SELECT_HI 6
`define STANDBY_WAIT_SELECT_LO 4
`define MEDIUM_DIV_SELECT_HI 1
`define MEDIUM_DIV_SELECT_LO 0
`define WATCH_PRESCALER_CLEAR_HI 3
`define WATCH_PRESCALER_CLEAR_LO 2

// ============================================================
// reset values
`define PORT_MODE_REG_TWO_RESET 8'h00
`define SYSTEM_CONTROL_REG_ONE_RESET 8'h00
`define TIMER_A_MODE_REG_RESET 4'h0

// ============================================================
// operating modes seen on the power mode input
`define MODE_ACTIVE_HIGH 3'h0
`define MODE_ACTIVE_MEDIUM 3'h1
`define MODE_SLEEP_HIGH 3'h2
`define MODE_SLEEP_MEDIUM 3'h3
`define MODE_SUBACTIVE 3'h4
`define MODE_SUBSLEEP 3'h5
`define MODE_WATCH 3'h6
`define MODE_STANDBY 3'h7

// ============================================================
// timing
`define CLOCK_PERIOD_NS 10
`define OSC_SETTLE_TIME_NS 10000
`define OSC_SETTLE_CYCLES (`OSC_SETTLE_TIME_NS / `CLOCK_PERIOD_NS)
`define MIN_WAIT_STATES 18'h00008
`define MAX_WAIT_STATES 131072
`define MEDIUM_MIN_DIVISOR 8'h10

`endif

// file: src/clock_prescaler_wakeup.v
// system and watch clock prescalers, subclock source select and wake-up wait
// assumes the power mode state machine drives POWER_MODE on REF_CLK
//
// Summary of operation
// - system prescaler is a 13-bit counter advancing once per system clock
// - reset clears the system prescaler; counting starts when reset ends
// - in standby, watch, subactive, subsleep the system prescaler stops at zero
// - system prescaler count has no read or write path
// - every system prescaler tap is shared; each peripheral picks its own
// - medium-speed mode feeds the system prescaler with oscillator over 16 to 128
// - watch prescaler is 5 bits fed by the subclock divided by four
// - reset clears the watch prescaler; counting starts when reset ends
// - watch prescaler keeps counting in low-power modes while subclock runs
// - writing ones to both clear bits of timer A mode clears watch prescaler
// - watch prescaler taps serve as the timekeeping timer time base
// - source select zero takes the resonator pin, one the external clock pin
// - select at bit 7; when set resonator is ignored and port pin is lost
// - wake wait chosen by three-bit field at bits 6 to 4
// - wait spans at least 8 and at most 131072 states
// - oscillator restarts when the wake-up interrupt is accepted
// - wake delay equals oscillator settling plus programmed wait
// - taps: system clock over 2 to 8192, watch clock over 1 to 128
//
// The APB register port and the address map are this design's own decisions.
`timescale 1ns/1ns
`include "clock_prescaler_wakeup_defines.vh"

module clock_prescaler_wakeup #(
    parameter OSC_SETTLE_CYCLES = `OSC_SETTLE_CYCLES,
    parameter MAX_WAIT_STATES = `MAX_WAIT_STATES
) (
    // clock and reset
    input wire REF_CLK,
    input wire RST,
    // apb slave
    input wire PSEL,
    input wire PENABLE,
    input wire PWRITE,
    input wire [11:0] PADDR,
    input wire [31:0] PWDATA,
    output reg [31:0] PRDATA,
    output reg PREADY,
    output reg PSLVERR,
    // power mode and wake-up
    input wire [2:0] POWER_MODE,
    input wire WAKE_ACCEPT,
    output reg MAIN_OSC_RUN,
    output reg CPU_CLK_EN,
    // subclock pins
    input wire SUB_OSC_IN,
    input wire EXT_SUBCLK_IN,
    output reg PORT3_BIT1_DISABLE,
    // prescaler taps
    output reg [12:0] SYS_TAPS,
    output reg [7:0] WATCH_TAPS
);

    // ============================================================
    // wake state machine codes
    localparam ST_RUN = 2'b00;
    localparam ST_HALT = 2'b01;
    localparam ST_SETTLE = 2'b10;
    localparam ST_WAIT = 2'b11;

    // ============================================================
    // functions
    function [17:0] wait_states;
        input [2:0] sel;
        reg [17:0] w;
        begin
            w = `MIN_WAIT_STATES << {sel, 1'b0};
            if (w > MAX_WAIT_STATES[17:0]) begin
                w = MAX_WAIT_STATES[17:0];
            end
            wait_states = w;
        end
    endfunction

    function is_stop_mode;
        input [2:0] m;
        begin
            is_stop_mode = (m == `MODE_STANDBY) || (m == `MODE_WATCH) ||
                           (m == `MODE_SUBACTIVE) || (m == `MODE_SUBSLEEP);
        end
    endfunction

    // ============================================================
    // registers
    reg [7:0] port_mode_reg_two_q;
    reg [7:0] system_control_reg_one_q;
    reg [3:0] timer_a_mode_reg_q;
    reg [12:0] sys_clock_prescaler_q;
    reg [4:0] watch_clock_prescaler_q;
    reg [1:0] sub_div_q;
    reg [2:0] sub_sync_q;
    reg sub_filt_q;
    reg [7:0] medium_cnt_q;
    reg [1:0] wake_state_q;
    reg [17:0] wake_cnt_q;
    reg stop_prev_q;

    wire ext_subclock_select = port_mode_reg_two_q[`EXT_SUBCLOCK_SELECT_BIT];
    wire [2:0] standby_wait_select =
        system_control_reg_one_q[`STANDBY_WAIT_SELECT_HI:`STANDBY_WAIT_SELECT_LO];
    wire [1:0] medium_div_select =
        system_control_reg_one_q[`MEDIUM_DIV_SELECT_HI:`MEDIUM_DIV_SELECT_LO];
    wire stop_mode = is_stop_mode(POWER_MODE);
    wire medium_mode = (POWER_MODE == `MODE_ACTIVE_MEDIUM) || (POWER_MODE == `MODE_SLEEP_MEDIUM);

    // ============================================================
    // apb decode
    wire apb_setup = PSEL && !PENABLE;
    wire apb_done = PSEL && PENABLE && PREADY;
    wire apb_wr = apb_done && PWRITE && !PSLVERR;
    wire addr_ok = (PADDR == `OFS_PORT_MODE_REG_TWO) || (PADDR == `OFS_SYSTEM_CONTROL_REG_ONE) ||
                   (PADDR == `OFS_TIMER_A_MODE_REG) || (PADDR == `OFS_STATUS);
    wire psw_clear = apb_wr && (PADDR == `OFS_TIMER_A_MODE_REG) &&
                     PWDATA[`WATCH_PRESCALER_CLEAR_HI] && PWDATA[`WATCH_PRESCALER_CLEAR_LO];

    reg [31:0] rd_mux;
    always @* begin
        rd_mux = 32'h0000_0000;
        case (PADDR)
            `OFS_PORT_MODE_REG_TWO: rd_mux[7:0] = port_mode_reg_two_q;
            `OFS_SYSTEM_CONTROL_REG_ONE: rd_mux[7:0] = system_control_reg_one_q;
            `OFS_TIMER_A_MODE_REG: rd_mux[3:0] = timer_a_mode_reg_q;
            // status shows wake state and watch count; system count stays hidden
            `OFS_STATUS: rd_mux[8:0] = {CPU_CLK_EN, MAIN_OSC_RUN, wake_state_q, watch_clock_prescaler_q};
            default: rd_mux = 32'h0000_0000;
        endcase
    end

    // one wait-free access: data and ready are registered in the setup cycle
    always @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            PRDATA <= 32'h0000_0000;
            PREADY <= 1'b0;
            PSLVERR <= 1'b0;
            port_mode_reg_two_q <= `PORT_MODE_REG_TWO_RESET;
            system_control_reg_one_q <= `SYSTEM_CONTROL_REG_ONE_RESET;
            timer_a_mode_reg_q <= `TIMER_A_MODE_REG_RESET;
        end else begin
            PREADY <= apb_setup;
            if (apb_setup) begin
                PRDATA <= PWRITE ? 32'h0000_0000 : rd_mux;
                PSLVERR <= !addr_ok;
            end else if (apb_done) begin
                PSLVERR <= 1'b0;
            end
            if (apb_wr) begin
                case (PADDR)
                    `OFS_PORT_MODE_REG_TWO: port_mode_reg_two_q <= PWDATA[7:0];
                    `OFS_SYSTEM_CONTROL_REG_ONE: system_control_reg_one_q <= PWDATA[7:0];
                    `OFS_TIMER_A_MODE_REG: timer_a_mode_reg_q <= PWDATA[3:0];
                    default: timer_a_mode_reg_q <= timer_a_mode_reg_q;
                endcase
            end
        end
    end

    // ============================================================
    // system clock prescaler
    wire [7:0] medium_limit = (`MEDIUM_MIN_DIVISOR << medium_div_select) - 8'h01;
    wire medium_hit = (medium_cnt_q == medium_limit);
    wire sys_advance = medium_mode ? medium_hit : 1'b1;
    wire sys_held = stop_mode || (wake_state_q != ST_RUN);

    always @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            sys_clock_prescaler_q <= 13'h0000;
            medium_cnt_q <= 8'h00;
            SYS_TAPS <= 13'h0000;
        end else begin
            if (sys_held || !medium_mode || medium_hit) begin
                medium_cnt_q <= 8'h00;
            end else begin
                medium_cnt_q <= medium_cnt_q + 8'h01;
            end
            if (sys_held) begin
                sys_clock_prescaler_q <= 13'h0000;
            end else if (sys_advance) begin
                sys_clock_prescaler_q <= sys_clock_prescaler_q + 13'h0001;
            end
            // bit n toggles at clock over 2^(n+1), shared by all consumers
            SYS_TAPS <= sys_clock_prescaler_q;
        end
    end

    // ============================================================
    // subclock select, synchroniser and watch clock prescaler
    // the mux precedes the synchroniser; a glitch on switching is accepted
    wire sub_pin = ext_subclock_select ? EXT_SUBCLK_IN : SUB_OSC_IN;
    wire sub_filt_d = (sub_sync_q[1] == sub_sync_q[2]) ? sub_sync_q[1] : sub_filt_q;
    wire sub_rise = sub_filt_d && !sub_filt_q;

    always @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            sub_sync_q <= 3'b000;
            sub_filt_q <= 1'b0;
            sub_div_q <= 2'b00;
            watch_clock_prescaler_q <= 5'h00;
            WATCH_TAPS <= 8'h00;
            PORT3_BIT1_DISABLE <= 1'b0;
        end else begin
            sub_sync_q <= {sub_sync_q[1:0], sub_pin};
            sub_filt_q <= sub_filt_d;
            if (sub_rise) begin
                sub_div_q <= sub_div_q + 2'b01;
            end
            // runs regardless of power mode
            if (psw_clear) begin
                watch_clock_prescaler_q <= 5'h00;
            end else if (sub_rise && sub_div_q == 2'b11) begin
                watch_clock_prescaler_q <= watch_clock_prescaler_q + 5'h01;
            end
            WATCH_TAPS <= {watch_clock_prescaler_q, sub_div_q, sub_filt_q};
            PORT3_BIT1_DISABLE <= ext_subclock_select;
        end
    end

    // ============================================================
    // wake-up: oscillator settling then programmed wait
    wire stop_enter = stop_mode && !stop_prev_q;

    always @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            wake_state_q <= ST_RUN;
            wake_cnt_q <= 18'h00000;
            stop_prev_q <= 1'b0;
            MAIN_OSC_RUN <= 1'b1;
            CPU_CLK_EN <= 1'b1;
        end else begin
            stop_prev_q <= stop_mode;
            case (wake_state_q)
                ST_RUN: begin
                    if (stop_enter) begin
                        wake_state_q <= ST_HALT;
                        MAIN_OSC_RUN <= 1'b0;
                        CPU_CLK_EN <= 1'b0;
                    end
                end
                ST_HALT: begin
                    if (WAKE_ACCEPT) begin
                        wake_state_q <= ST_SETTLE;
                        wake_cnt_q <= 18'h00000;
                        MAIN_OSC_RUN <= 1'b1;
                    end
                end
                ST_SETTLE: begin
                    if (wake_cnt_q == OSC_SETTLE_CYCLES[17:0] - 18'h00001) begin
                        wake_state_q <= ST_WAIT;
                        wake_cnt_q <= 18'h00000;
                    end else begin
                        wake_cnt_q <= wake_cnt_q + 18'h00001;
                    end
                end
                ST_WAIT: begin
                    if (wake_cnt_q == wait_states(standby_wait_select) - 18'h00001) begin
                        wake_state_q <= ST_RUN;
                        CPU_CLK_EN <= 1'b1;
                    end else begin
                        wake_cnt_q <= wake_cnt_q + 18'h00001;
                    end
                end
                default: wake_state_q <= ST_RUN;
            endcase
        end
    end

endmodule

// file: bench/clock_prescaler_wakeup_monitor.sv
// checker on the ports of the clock prescaler and wake-up block
// assumes one clock domain and the bind at the foot
`timescale 1ns/1ns
module clock_prescaler_wakeup_monitor #(
    parameter OSC_SETTLE_CYCLES = 4,
    parameter MAX_WAIT_STATES = 64
) (
    // clock and reset
    input wire REF_CLK,
    input wire RST,
    // apb
    input wire PSEL,
    input wire PENABLE,
    input wire PWRITE,
    input wire [11:0] PADDR,
    input wire [31:0] PWDATA,
    input wire PREADY,
    input wire PSLVERR,
    // mode, wake and outputs
    input wire [2:0] POWER_MODE,
    input wire WAKE_ACCEPT,
    input wire MAIN_OSC_RUN,
    input wire CPU_CLK_EN,
    input wire PORT3_BIT1_DISABLE,
    input wire [12:0] SYS_TAPS
);
    // =====
    // gated span counter, too long for a repetition
    reg [17:0] gate_q;
    always @(posedge REF_CLK or posedge RST) begin
        if (RST) gate_q <= 18'h0;
        else gate_q <= (MAIN_OSC_RUN && !CPU_CLK_EN) ? gate_q + 18'h1 : 18'h0;
    end
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (RST);
    // =====
    // properties, one per rule
    property p_sys_inc; (POWER_MODE == 3'h0 && CPU_CLK_EN)[*3] |=> SYS_TAPS == $past(SYS_TAPS) + 13'h1; endproperty
    a_sys_inc: assert property (p_sys_inc) else $error("prescaler step wrong");
    property p_stop_zero; POWER_MODE[2] [*3] |=> SYS_TAPS == 13'h0; endproperty
    a_stop_zero: assert property (p_stop_zero) else $error("prescaler not zero");
    property p_halt; POWER_MODE[2] && CPU_CLK_EN && !$past(POWER_MODE[2]) |=> ##[0:1] !CPU_CLK_EN && !MAIN_OSC_RUN; endproperty
    a_halt: assert property (p_halt) else $error("no halt on stop");
    property p_wake_osc; !MAIN_OSC_RUN && WAKE_ACCEPT |=> MAIN_OSC_RUN; endproperty
    a_wake_osc: assert property (p_wake_osc) else $error("osc not restarted");
    property p_min_wait; $rose(MAIN_OSC_RUN) && !$past(RST) |-> !CPU_CLK_EN [*8]; endproperty
    a_min_wait: assert property (p_min_wait) else $error("wait too short");
    property p_max_wait; gate_q <= OSC_SETTLE_CYCLES + MAX_WAIT_STATES + 4; endproperty
    a_max_wait: assert property (p_max_wait) else $error("wait too long");
    property p_ready; PSEL && !PENABLE |=> PREADY ##1 !PREADY; endproperty
    a_ready: assert property (p_ready) else $error("ready timing wrong");
    property p_err; PREADY |-> PSLVERR == (PADDR[11:4] != 8'h0 || PADDR[1:0] != 2'h0); endproperty
    a_err: assert property (p_err) else $error("error response wrong");
    property p_port; PSEL && PENABLE && PREADY && PWRITE && PADDR == 12'h000 |=> ##1
        PORT3_BIT1_DISABLE == $past(PWDATA[7], 2); endproperty
    a_port: assert property (p_port) else $error("port disable wrong");
    c_wake: cover property ($rose(CPU_CLK_EN));
    c_err: cover property (PREADY && PSLVERR);
    c_med: cover property (POWER_MODE == 3'h1 [*8]);
endmodule
bind clock_prescaler_wakeup clock_prescaler_wakeup_monitor #(.OSC_SETTLE_CYCLES(OSC_SETTLE_CYCLES),
    .MAX_WAIT_STATES(MAX_WAIT_STATES)) u_mon (.REF_CLK(REF_CLK), .RST(RST), .PSEL(PSEL),
    .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PREADY(PREADY),
    .PSLVERR(PSLVERR), .POWER_MODE(POWER_MODE), .WAKE_ACCEPT(WAKE_ACCEPT), .MAIN_OSC_RUN(MAIN_OSC_RUN),
    .CPU_CLK_EN(CPU_CLK_EN), .PORT3_BIT1_DISABLE(PORT3_BIT1_DISABLE), .SYS_TAPS(SYS_TAPS));

// file: bench/clock_prescaler_wakeup_tb_top.sv
// self-checking bench for the clock prescaler and wake-up block
// assumes no fixed apb wait count and a short settle count; subclock made here
`timescale 1ns/1ns
`include "clock_prescaler_wakeup_defines.vh"
module clock_prescaler_wakeup_tb_top;
    logic clk = 0, rst = 1, psel = 0, pen = 0, pwr = 0, wake = 0, sub = 0, ext = 0, err;
    logic pready, pslverr, osc, cpu, p3dis;
    logic [11:0] adr = 0;
    logic [31:0] wd = 0, rd, prdata;
    logic [2:0] mode = 0;
    logic [12:0] taps, t0;
    logic [7:0] wtaps;
    integer miscompares = 0, total_checks = 0, n;
    always #5 clk = ~clk;
    clock_prescaler_wakeup #(.OSC_SETTLE_CYCLES(4), .MAX_WAIT_STATES(64)) DUT (
        .REF_CLK(clk), .RST(rst), .PSEL(psel), .PENABLE(pen), .PWRITE(pwr), .PADDR(adr),
        .PWDATA(wd), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .POWER_MODE(mode),
        .WAKE_ACCEPT(wake), .MAIN_OSC_RUN(osc), .CPU_CLK_EN(cpu), .SUB_OSC_IN(sub),
        .EXT_SUBCLK_IN(ext), .PORT3_BIT1_DISABLE(p3dis), .SYS_TAPS(taps), .WATCH_TAPS(wtaps));
    // =====
    task check(input logic [39:0] got, input logic [39:0] exp);
        total_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // one transfer, then an idle edge so the next setup never lands in the same step
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel <= 1;
        pwr <= w;
        adr <= a;
        wd <= d;
        @(posedge clk);
        pen <= 1;
        // no wait-state count is assumed; only the watchdog ends a hung transfer
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 0;
        pen <= 0;
        @(posedge clk);
    endtask
    // k rising edges; half period of 4 clocks clears the input filter
    task subp(input integer k, input logic on_ext);
        repeat (2 * k) begin
            if (on_ext) ext <= ~ext;
            else sub <= ~sub;
            repeat (4) @(posedge clk);
        end
        repeat (4) @(posedge clk);
    endtask
    // leave stop mode by an accepted wake-up, n counts edges until cpu clocks return
    task wake_count;
        mode <= `MODE_ACTIVE_HIGH;
        wake <= 1;
        @(posedge clk);
        wake <= 0;
        n = 0;
        while (cpu !== 1'b1 && n < 500) begin
            @(posedge clk);
            n++;
        end
    endtask
    task complete_run;
        $display("checks %0d miscompares %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    initial begin
        #200000;
        miscompares++;
        complete_run;
    end
    // =====
    initial begin
        repeat (8) @(posedge clk);
        check({taps, wtaps, osc, cpu, p3dis}, {13'h0, 8'h0, 3'b110});
        rst <= 0;
        @(posedge clk);
        apb(0, `OFS_STATUS, 0);
        check(rd, 32'h180);
        t0 = taps;
        @(posedge clk);
        check(taps, 13'(t0 + 13'h1));
        apb(0, 12'h010, 0);
        check({err, rd}, {1'b1, 32'h0});
        apb(1, `OFS_SYSTEM_CONTROL_REG_ONE, 32'h10);
        subp(8, 0);
        apb(0, `OFS_STATUS, 0);
        check({wtaps[7:3], rd}, {5'h2, 32'h182});
        mode <= `MODE_WATCH;
        subp(4, 0);
        check(taps, 0);
        apb(0, `OFS_STATUS, 0);
        check(rd, 32'h23);
        wake_count;
        check(osc, 1);
        check(n >= 36 && n <= 40, 1);
        apb(1, `OFS_TIMER_A_MODE_REG, 32'h8);
        apb(0, `OFS_STATUS, 0);
        check(rd, 32'h183);
        apb(1, `OFS_TIMER_A_MODE_REG, 32'hc);
        apb(0, `OFS_STATUS, 0);
        check(rd, 32'h180);
        apb(1, `OFS_PORT_MODE_REG_TWO, 32'h80);
        @(posedge clk);
        check(p3dis, 1);
        subp(4, 0);
        subp(4, 1);
        apb(0, `OFS_STATUS, 0);
        check(rd, 32'h181);
        apb(1, `OFS_SYSTEM_CONTROL_REG_ONE, 32'h11);
        apb(0, `OFS_SYSTEM_CONTROL_REG_ONE, 0);
        check(rd, 32'h11);
        mode <= `MODE_ACTIVE_MEDIUM;
        repeat (4) @(posedge clk);
        t0 = taps;
        repeat (32) @(posedge clk);
        check(taps, 13'(t0 + 13'h1));
        // shortest wait: settle 4 plus 8 states, one edge to see the enable
        apb(1, `OFS_SYSTEM_CONTROL_REG_ONE, 32'h0);
        mode <= `MODE_SUBACTIVE;
        repeat (4) @(posedge clk);
        check({taps, osc, cpu}, {13'h0, 2'b00});
        wake_count;
        check(n >= 12 && n <= 14, 1);
        check(osc, 1);
        complete_run;
    end
endmodule
